// ### include/cfcmd_pkg.sv
// Shared constants and types for the connection command field block
package cfcmd_pkg;
	localparam int CFCMD_CMD_W = 2;
	// Command field encodings
	localparam logic [1:0] CFCMD_CMD_NONE = 2'h0;
	localparam logic [1:0] CFCMD_CMD_START = 2'h1;
	localparam logic [1:0] CFCMD_CMD_TRACE = 2'h2;
	localparam logic [1:0] CFCMD_CMD_STOP = 2'h3;
	// Reset values
	localparam logic [1:0] CFCMD_FIELD_RST = 2'h0;
	localparam logic CFCMD_ARMED_RST = 1'b1;
	localparam logic CFCMD_HOLD_RST = 1'b0;
	// Connection state machine states
	typedef enum logic [2:0] {
		CFCMD_OFF,
		CFCMD_BREAK,
		CFCMD_CONNECT,
		CFCMD_ACTIVE,
		CFCMD_TRACE
	} cfcmd_conn_e;
	// Insertion state machine states, as reported by the companion machine
	typedef enum logic [1:0] {
		CFCMD_REMOVED,
		CFCMD_INS_SCRUB,
		CFCMD_INSERTED,
		CFCMD_REM_SCRUB
	} cfcmd_ins_e;
endpackage

// ### verilog/cfcmd_capture.sv
// Command field capture, start re-arm tracking and command pulses
`timescale 1ns/10ps
module cfcmd_capture (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic [cfcmd_pkg::CFCMD_CMD_W-1:0] data_i,
	output logic [cfcmd_pkg::CFCMD_CMD_W-1:0] field_o,
	output logic start_o,
	output logic trace_o,
	output logic stop_o,
	output logic armed_o
);
	import cfcmd_pkg::*;

	typedef struct packed {
		logic [CFCMD_CMD_W-1:0] field;
		logic start;
		logic trace;
		logic stop;
		logic armed;
	} cfcmd_cap_s;

	cfcmd_cap_s s;
	cfcmd_cap_s next_s;

	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.trace = 1'b0;
		next_s.stop = 1'b0;
		if (wr_i) begin
			next_s.field = data_i; // [RL10]
			case (data_i)
				CFCMD_CMD_NONE: begin
					next_s.armed = 1'b1; // [RL5]
				end
				CFCMD_CMD_START: begin
					if (s.armed) begin
						next_s.start = 1'b1; // [RL2]
						next_s.armed = 1'b0; // [RL5]
					end
				end
				CFCMD_CMD_TRACE: begin
					next_s.trace = 1'b1; // [RL2]
				end
				default: begin
					next_s.stop = 1'b1; // [RL2]
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '{field: CFCMD_FIELD_RST, start: 1'b0, trace: 1'b0, stop: 1'b0,
				armed: CFCMD_ARMED_RST};
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign field_o = s.field;
	assign start_o = s.start;
	assign trace_o = s.trace;
	assign stop_o = s.stop;
	assign armed_o = s.armed;
endmodule

// ### verilog/cfcmd_top.sv
// Connection state machine command field: decode, forcing, hold in break, scrub ordering
// How it works
// [RL1] A nonzero command write moves the connection machine straight to break, trace or off.
// [RL2] Code 00 only re-arms start, 01 is start to break, 10 is trace, 11 is stop to off.
// [RL3] Start and stop force break or off from any current state.
// [RL4] Trace is obeyed only in the active state and is otherwise dropped with no change.
// [RL5] A second start counts only after software has written zero and then start again.
// [RL6] Break reached by quiet line or timeout never advances to connect.
// [RL7] Such a break is held until a start command is written.
// [RL8] Start or stop while inserted raises a scrub request.
// [RL9] Start or stop during an insertion or removal scrub waits for the scrub to end.
// [RL10] Each write is sampled once and the field keeps its value until rewritten.
`timescale 1ns/10ps
module cfcmd_top (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic cmd_wr_i,
	input wire logic [cfcmd_pkg::CFCMD_CMD_W-1:0] cmd_data_i,
	input wire cfcmd_pkg::cfcmd_ins_e insertion_state_i,
	input wire logic quiet_line_state_i,
	input wire logic timeout_i,
	input wire logic signal_done_i,
	input wire logic trace_done_i,
	output cfcmd_pkg::cfcmd_conn_e conn_state_o,
	output logic [cfcmd_pkg::CFCMD_CMD_W-1:0] cmd_field_o,
	output logic start_armed_o,
	output logic scrub_req_o,
	output logic cmd_pending_o,
	output logic break_hold_o
);
	import cfcmd_pkg::*;

	typedef struct packed {
		cfcmd_conn_e conn;
		logic break_hold;
		logic pend_valid;
		logic pend_stop;
		logic scrub_req;
	} cfcmd_top_s;

	cfcmd_top_s s;
	cfcmd_top_s next_s;
	logic start_cmd;
	logic trace_cmd;
	logic stop_cmd;

	cfcmd_capture u_capture (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.wr_i(cmd_wr_i),
		.data_i(cmd_data_i),
		.field_o(cmd_field_o),
		.start_o(start_cmd),
		.trace_o(trace_cmd),
		.stop_o(stop_cmd),
		.armed_o(start_armed_o)
	);

	// Scrub in progress in the insertion machine
	function automatic logic cfcmd_scrubbing(input cfcmd_ins_e ins);
		cfcmd_scrubbing = (ins == CFCMD_INS_SCRUB) || (ins == CFCMD_REM_SCRUB);
	endfunction

	always_comb begin
		next_s = s;
		next_s.scrub_req = 1'b0;
		// Autonomous progress of the connection machine
		case (s.conn)
			CFCMD_BREAK: begin
				if (!s.break_hold && !quiet_line_state_i) begin
					next_s.conn = CFCMD_CONNECT;
				end
			end
			CFCMD_CONNECT: begin
				if (quiet_line_state_i || timeout_i) begin
					next_s.conn = CFCMD_BREAK;
					next_s.break_hold = 1'b1; // [RL6]
				end else if (signal_done_i) begin
					next_s.conn = CFCMD_ACTIVE;
				end
			end
			CFCMD_ACTIVE: begin
				if (quiet_line_state_i || timeout_i) begin
					next_s.conn = CFCMD_BREAK;
					next_s.break_hold = 1'b1; // [RL6]
				end
			end
			CFCMD_TRACE: begin
				if (trace_done_i) begin
					next_s.conn = CFCMD_OFF;
				end
			end
			default: begin
				next_s.conn = s.conn;
			end
		endcase
		// Deferred start or stop, released when the scrub ends
		if (s.pend_valid && !cfcmd_scrubbing(insertion_state_i)) begin
			next_s.pend_valid = 1'b0;
			next_s.conn = s.pend_stop ? CFCMD_OFF : CFCMD_BREAK; // [RL9]
			if (!s.pend_stop) begin
				next_s.break_hold = 1'b0;
			end
		end
		// New start or stop overrides any autonomous move
		if (start_cmd || stop_cmd) begin
			if (cfcmd_scrubbing(insertion_state_i)) begin
				next_s.pend_valid = 1'b1; // [RL9]
				next_s.pend_stop = stop_cmd;
				next_s.conn = s.conn;
			end else begin
				next_s.pend_valid = 1'b0;
				next_s.conn = stop_cmd ? CFCMD_OFF : CFCMD_BREAK; // [RL1] [RL3]
				if (start_cmd) begin
					next_s.break_hold = 1'b0; // [RL7]
				end
				if (insertion_state_i == CFCMD_INSERTED) begin
					next_s.scrub_req = 1'b1; // [RL8]
				end
			end
		end
		// Trace only from active
		if (trace_cmd && s.conn == CFCMD_ACTIVE && !s.pend_valid) begin
			next_s.conn = CFCMD_TRACE; // [RL4]
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '{conn: CFCMD_OFF, break_hold: CFCMD_HOLD_RST, pend_valid: 1'b0,
				pend_stop: 1'b0, scrub_req: 1'b0};
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign conn_state_o = s.conn;
	assign scrub_req_o = s.scrub_req;
	assign cmd_pending_o = s.pend_valid;
	assign break_hold_o = s.break_hold;
endmodule

// ### tb/cfcmd_properties.sv
// Checker for the connection command field block
`timescale 1ns/10ps
module cfcmd_properties (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic cmd_wr_i,
	input wire logic [1:0] cmd_data_i,
	input wire cfcmd_pkg::cfcmd_ins_e insertion_state_i,
	input wire cfcmd_pkg::cfcmd_conn_e conn_state_o,
	input wire logic [1:0] cmd_field_o,
	input wire logic start_armed_o,
	input wire logic scrub_req_o,
	input wire logic cmd_pending_o,
	input wire logic break_hold_o
);
	import cfcmd_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	wire wr = ce_i && cmd_wr_i;
	field_capture_a: assert property (wr |=> cmd_field_o == $past(cmd_data_i))
		else $error("field not captured");
	start_break_a: assert property (wr && cmd_data_i == 2'h1 && start_armed_o
		##1 ce_i && !insertion_state_i[0] |=> conn_state_o == CFCMD_BREAK) else $error("start");
	stop_off_a: assert property (wr && cmd_data_i == 2'h3
		##1 ce_i && !insertion_state_i[0] |=> conn_state_o == CFCMD_OFF) else $error("stop");
	trace_taken_a: assert property (wr && cmd_data_i == 2'h2 ##1 ce_i && !cmd_pending_o
		&& conn_state_o == CFCMD_ACTIVE |=> conn_state_o == CFCMD_TRACE) else $error("trace");
	trace_dropped_a: assert property (wr && cmd_data_i == 2'h2
		##1 conn_state_o < CFCMD_ACTIVE |=> conn_state_o != CFCMD_TRACE) else $error("trace in");
	scrub_request_a: assert property (wr && cmd_data_i == 2'h3
		##1 ce_i && insertion_state_i == CFCMD_INSERTED |=> scrub_req_o) else $error("scrub");
	scrub_release_a: assert property (cmd_pending_o && ce_i && !insertion_state_i[0]
		|=> !cmd_pending_o && conn_state_o inside {CFCMD_BREAK, CFCMD_OFF}) else $error("wait");
	break_hold_a: assert property (break_hold_o && conn_state_o == CFCMD_BREAK
		|=> conn_state_o != CFCMD_CONNECT) else $error("left held break");
endmodule
bind cfcmd_top cfcmd_properties i_cfcmd_properties (.core_clk_i, .resetn_i, .ce_i, .cmd_wr_i,
	.cmd_data_i, .insertion_state_i, .conn_state_o, .cmd_field_o, .start_armed_o,
	.scrub_req_o, .cmd_pending_o, .break_hold_o);

// ### tb/tb.sv
// Self-checking bench for the connection command field block
`timescale 1ns/10ps
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
	$display("Error %0t %h %h", $time, a, e); end end
module tb;
	import cfcmd_pkg::*;
	logic core_clk_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1, cmd_wr_i = 1'h0;
	logic quiet_line_state_i = 1'h1, timeout_i = 1'h0, signal_done_i = 1'h0, trace_done_i = 1'h0;
	logic [1:0] cmd_data_i = 2'h0;
	cfcmd_ins_e insertion_state_i = CFCMD_REMOVED;
	cfcmd_conn_e conn_state_o;
	logic [1:0] cmd_field_o;
	logic start_armed_o, scrub_req_o, cmd_pending_o, break_hold_o;
	int mismatches = 0, checks_done = 0;
	cfcmd_top i_cfcmd_top (.core_clk_i, .resetn_i, .ce_i, .cmd_wr_i, .cmd_data_i,
		.insertion_state_i, .quiet_line_state_i, .timeout_i, .signal_done_i, .trace_done_i,
		.conn_state_o, .cmd_field_o, .start_armed_o, .scrub_req_o, .cmd_pending_o, .break_hold_o);
	task automatic stop_test;
		if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// One write, returns once the command has acted
	task automatic w(input logic [1:0] v);
		cmd_wr_i = 1'h1;
		cmd_data_i = v;
		cy(1);
		cmd_wr_i = 1'h0;
		cy(1);
	endtask
	task automatic to_active;
		w(2'h0);
		w(2'h1);
		quiet_line_state_i = 1'h0;
		cy(1);
		signal_done_i = 1'h1;
		cy(1);
		signal_done_i = 1'h0;
	endtask
	task automatic t_codes;
		w(2'h1);
		`CK(cmd_field_o, 2'h1)
		`CK(conn_state_o, CFCMD_BREAK)
		w(2'h2);
		`CK(conn_state_o, CFCMD_BREAK)
		w(2'h3);
		`CK(conn_state_o, CFCMD_OFF)
		w(2'h1);
		`CK(conn_state_o, CFCMD_OFF)
		w(2'h0);
		`CK(start_armed_o, 1'h1)
		`CK(conn_state_o, CFCMD_OFF)
	endtask
	task automatic t_trace;
		to_active;
		`CK(conn_state_o, CFCMD_ACTIVE)
		w(2'h2);
		`CK(conn_state_o, CFCMD_TRACE)
		// Clock enable low freezes the machine
		ce_i = 1'h0;
		trace_done_i = 1'h1;
		cy(2);
		`CK(conn_state_o, CFCMD_TRACE)
		ce_i = 1'h1;
		cy(1);
		`CK(conn_state_o, CFCMD_OFF)
		trace_done_i = 1'h0;
	endtask
	task automatic t_hold;
		to_active;
		quiet_line_state_i = 1'h1;
		cy(1);
		`CK(break_hold_o, 1'h1)
		quiet_line_state_i = 1'h0;
		cy(3);
		`CK(conn_state_o, CFCMD_BREAK)
		w(2'h0);
		w(2'h1);
		cy(1);
		`CK(conn_state_o, CFCMD_CONNECT)
	endtask
	task automatic t_scrub;
		quiet_line_state_i = 1'h1;
		insertion_state_i = CFCMD_INSERTED;
		w(2'h3);
		`CK(scrub_req_o, 1'h1)
		cy(1);
		`CK(scrub_req_o, 1'h0)
		insertion_state_i = CFCMD_INS_SCRUB;
		w(2'h0);
		w(2'h1);
		`CK(cmd_pending_o, 1'h1)
		`CK(conn_state_o, CFCMD_OFF)
		insertion_state_i = CFCMD_INSERTED;
		cy(2);
		`CK(conn_state_o, CFCMD_BREAK)
	endtask
	initial forever #5 core_clk_i = ~core_clk_i;
	initial begin
		#5000;
		mismatches++;
		stop_test;
	end
	initial begin
		cy(2);
		resetn_i = 1'h1;
		t_codes;
		t_trace;
		t_hold;
		t_scrub;
		stop_test;
	end
endmodule
